// ---- core/rtcs_top.sv ----
// Clock-register and power-fail front end of a byte-wide clock memory
//
// Functional notes
// RQ1: Read when selected, write high; output enable drives
// RQ2: Write spans both enables low; commit at end
// RQ3: Power fail deselects, floats data, ignores inputs
// RQ4: Power fail mid-write drops only that byte
// RQ5: Protection applies at once on power fail
// RQ6: Battery backs array below switchover level
// RQ7: Battery checked at power-up, sets low flag
// RQ8: Low flag blocks the first write attempted
// RQ9: Low flag clears after that first write
// RQ10: Host keeps chip enable high during power-up
// RQ11: Holding bytes separate from running counters
// RQ12: Snapshot bit freezes holding byte refresh
// RQ13: Frozen holding bytes show time at halt
// RQ14: All holding bytes refresh in one step
// RQ15: Refresh resumes within a second after snapshot
// RQ16: Time-load bit also freezes holding refresh
// RQ17: Host loads 24-hour BCD time values
// RQ18: Clearing time-load copies holding into counters
// RQ19: Host writes test and reserved bits zero
// RQ20: Control byte: load, snapshot, sign, calibration
// RQ21: Oscillator-halt bit stops the oscillator
// RQ22: Oscillator-halt bit is one after reset
// RQ23: Oscillator runs within a second after clear
// RQ24: Low bytes are storage; power fail input
// RQ25: Only completed writes change stored bits
`timescale 1ns/10ps
`default_nettype none
module rtcs_top #(
  parameter int unsigned SEC_CYCLES = rtcs_pkg::SEC_CYCLES  // Cycles per second
) (
  input  wire logic        i_ref_clk,        // 200 MHz reference clock
  input  wire logic        i_reset,          // Async reset, active high
  input  wire logic        i_ce_n,           // Chip enable, active low
  input  wire logic        i_oe_n,           // Output enable, active low
  input  wire logic        i_we_n,           // Write enable, active low
  input  wire logic [10:0] i_addr,           // Byte address
  input  wire logic [7:0]  i_dq,             // Data from host
  output logic      [7:0]  o_dq,             // Data to host
  output logic             o_dq_oe_n,        // Low while driving data
  input  wire logic        i_power_fail,     // Supply in power-fail window
  input  wire logic        i_supply_above_so, // Supply above switchover level
  input  wire logic        i_battery_weak,   // Battery check result
  output logic             o_battery_backup, // Array fed from battery
  output logic             o_battery_low,    // Battery-low flag
  output logic             o_osc_running     // Oscillator running
);

  // ----------------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------------
  // True for the eight clock bytes at the top of the space
  function automatic logic is_clock_addr(input logic [10:0] a);
    is_clock_addr = (a >= rtcs_pkg::CLOCK_CONTROL_OFS);
  endfunction

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic        rd_sel;          // Read cycle seen this clock
  logic        wr_act;          // Both enables low, supply good
  logic        wr_act_r;        // Write active last clock
  logic [10:0] wr_addr_r;       // Address captured during write
  logic [7:0]  wr_data_r;       // Data captured during write
  logic        wr_end;          // Write terminated this clock
  logic        commit;          // Write allowed to change state
  logic        pf_r;            // Power fail last clock
  logic        batt_low_r;      // Battery-low flag
  logic [7:0]  ctrl_r;          // Control byte
  logic        load_bit_d_r;    // Time-load bit last clock
  logic        load_pulse;      // Time-load bit just cleared
  logic        frozen;          // Holding refresh halted
  logic        osc_halt_r;      // Oscillator-halt bit
  logic        ftest_r;         // Frequency test bit
  logic [7:0]  hold_r [1:7];    // Holding bytes sec..year
  logic [55:0] hold_flat;       // Holding bytes for loading
  logic [55:0] count;           // Running counters
  logic [rtcs_pkg::DIV_W-1:0] div_r; // One-second divider
  logic        sec_tick;        // One-second enable pulse
  logic [7:0]  store_rd;        // Storage read value
  logic [7:0]  rd_byte;         // Selected read value
  logic [7:0]  dq_r;            // Registered data out
  logic        dq_oe_n_r;       // Registered output enable
  logic        bbk_r;           // Battery backup state
  logic        osc_run_r;       // Oscillator state

  // ----------------------------------------------------------------------
  // Bus cycle detection
  // ----------------------------------------------------------------------
  // Inputs are synchronous to the clock; power fail masks everything
  assign rd_sel = !i_power_fail && !i_ce_n && i_we_n && !i_oe_n;  // RQ1 RQ3
  assign wr_act = !i_power_fail && !i_ce_n && !i_we_n;           // RQ2 RQ3

  // Ends on the earlier rising enable; an aborted cycle never commits
  assign wr_end = wr_act_r && !wr_act && !i_power_fail;          // RQ2 RQ4 RQ5
  assign commit = wr_end && !batt_low_r;                          // RQ8 RQ25

  // Track the cycle and follow the data until it ends
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      wr_act_r  <= 1'b0;
      wr_addr_r <= 11'h000;
      wr_data_r <= 8'h00;
    end else begin
      wr_act_r <= wr_act;
      if (wr_act) begin
        // Last value before the end is the one stored
        wr_addr_r <= i_addr;                                      // RQ2
        wr_data_r <= i_dq;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Power supervision
  // ----------------------------------------------------------------------
  // Battery flag: set on supply recovery, cleared by first write
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      pf_r       <= 1'b0;
      batt_low_r <= 1'b0;
    end else begin
      pf_r <= i_power_fail;
      if (pf_r && !i_power_fail) begin
        // Set wins: the check happens as the supply rises
        batt_low_r <= i_battery_weak;                             // RQ7
      end else if (wr_end) begin
        batt_low_r <= 1'b0;                                       // RQ9
      end
    end
  end

  // Switchover: battery carries the array below the level
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      bbk_r <= 1'b0;
    end else begin
      bbk_r <= !i_supply_above_so;                                // RQ6
    end
  end

  // ----------------------------------------------------------------------
  // Control byte and separate bits
  // ----------------------------------------------------------------------
  // Sign and calibration are stored only; no trimming is modelled
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      ctrl_r <= rtcs_pkg::CTRL_RESET;
    end else if (commit && wr_addr_r == rtcs_pkg::CLOCK_CONTROL_OFS) begin
      ctrl_r <= wr_data_r;                                        // RQ20 RQ25
    end
  end

  // Oscillator halt and test bits take effect without the load bit
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      osc_halt_r <= rtcs_pkg::OSC_HALT_RESET;                     // RQ22
      ftest_r    <= 1'b0;
    end else if (commit) begin
      if (wr_addr_r == rtcs_pkg::SECONDS_AND_OSC_HALT_OFS) begin
        osc_halt_r <= wr_data_r[rtcs_pkg::OSC_HALT_BIT];          // RQ21
      end
      if (wr_addr_r == rtcs_pkg::WEEKDAY_AND_TEST_OFS) begin
        ftest_r <= wr_data_r[rtcs_pkg::FREQ_TEST_BIT];
      end
    end
  end

  // Falling time-load bit triggers the counter load
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      load_bit_d_r <= 1'b0;
    end else begin
      load_bit_d_r <= ctrl_r[rtcs_pkg::CTRL_TIME_LOAD_BIT];
    end
  end
  assign load_pulse = load_bit_d_r && !ctrl_r[rtcs_pkg::CTRL_TIME_LOAD_BIT]; // RQ18
  assign frozen = ctrl_r[rtcs_pkg::CTRL_TIME_LOAD_BIT]                       // RQ16
               || ctrl_r[rtcs_pkg::CTRL_SNAPSHOT_BIT];                        // RQ12

  // ----------------------------------------------------------------------
  // Oscillator and one-second divider
  // ----------------------------------------------------------------------
  // Halted divider restarts from zero, so the first second is full
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      div_r     <= '0;
      osc_run_r <= 1'b0;
    end else begin
      osc_run_r <= !osc_halt_r;                                   // RQ23
      if (osc_halt_r || sec_tick) begin
        div_r <= '0;                                              // RQ21
      end else begin
        div_r <= div_r + 1'b1;
      end
    end
  end
  assign sec_tick = !osc_halt_r && (div_r == rtcs_pkg::DIV_W'(SEC_CYCLES - 1));

  // ----------------------------------------------------------------------
  // Running counters, kept apart from the holding bytes
  // ----------------------------------------------------------------------
  assign hold_flat = {hold_r[7], hold_r[6], hold_r[5], hold_r[4],
                      hold_r[3], hold_r[2], hold_r[1]};

  // Counters keep counting whatever the holding bytes do
  rtcs_timekeep u_timekeep (
    .i_ref_clk  (i_ref_clk),
    .i_reset    (i_reset),
    .i_tick     (sec_tick),                                       // RQ11
    .i_load     (load_pulse),                                     // RQ18
    .i_load_val (hold_flat),
    .o_count    (count)
  );

  // ----------------------------------------------------------------------
  // Holding bytes
  // ----------------------------------------------------------------------
  // Every byte copies in the same cycle, so no update is ever torn;
  // a host write while unfrozen is overwritten, as the host must freeze
  genvar gi;
  generate
    for (gi = 1; gi <= 7; gi++) begin : g_hold
      always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
          hold_r[gi] <= 8'h00;
        end else if (!frozen && !load_pulse) begin
          hold_r[gi] <= count[gi*8-1 -: 8];                       // RQ14 RQ15
        end else if (commit && wr_addr_r == rtcs_pkg::CLOCK_CONTROL_OFS + 11'(gi)) begin
          hold_r[gi] <= wr_data_r;                                // RQ13 RQ25
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Plain storage
  // ----------------------------------------------------------------------
  // Completed writes below the control byte land here
  rtcs_store u_store (
    .i_ref_clk (i_ref_clk),
    .i_wr_en   (commit && !is_clock_addr(wr_addr_r)),             // RQ24 RQ4
    .i_wr_addr (wr_addr_r),
    .i_wr_data (wr_data_r),
    .i_rd_addr (i_addr),
    .o_rd_data (store_rd)
  );

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  // Halt and test bits live outside the holding bytes and merge on read
  always_comb begin
    rd_byte = store_rd;
    if (is_clock_addr(i_addr)) begin
      unique case (i_addr)
        rtcs_pkg::CLOCK_CONTROL_OFS: begin
          rd_byte = ctrl_r;
        end
        rtcs_pkg::SECONDS_AND_OSC_HALT_OFS: begin
          rd_byte = {osc_halt_r, hold_r[1][6:0]};
        end
        rtcs_pkg::WEEKDAY_AND_TEST_OFS: begin
          rd_byte = {hold_r[4][7], ftest_r, hold_r[4][5:0]};
        end
        default: begin
          rd_byte = hold_r[i_addr[2:0]];
        end
      endcase
    end
  end

  // Outputs registered; high impedance whenever not reading
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      dq_r      <= 8'h00;
      dq_oe_n_r <= 1'b1;
    end else begin
      dq_r      <= rd_byte;                                       // RQ1
      dq_oe_n_r <= !rd_sel;                                       // RQ1 RQ3
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign o_dq             = dq_r;
  assign o_dq_oe_n        = dq_oe_n_r;
  assign o_battery_backup = bbk_r;
  assign o_battery_low    = batt_low_r;
  assign o_osc_running    = osc_run_r;

endmodule
`default_nettype wire

// ---- include/rtcs_pkg.sv ----
// Package: shared constants of the clock-register and power-fail front end
package rtcs_pkg;

  // ----------------------------------------------------------------------
  // Bus widths and address map
  // ----------------------------------------------------------------------
  localparam int unsigned ADDR_W     = 11;             // 2048-byte space
  localparam int unsigned DATA_W     = 8;              // Byte-wide data
  localparam logic [10:0] CLOCK_CONTROL_OFS        = 11'h7F8;
  localparam logic [10:0] SECONDS_AND_OSC_HALT_OFS = 11'h7F9;
  localparam logic [10:0] MINUTES_BCD_OFS          = 11'h7FA;
  localparam logic [10:0] HOURS_BCD_OFS            = 11'h7FB;
  localparam logic [10:0] WEEKDAY_AND_TEST_OFS     = 11'h7FC;
  localparam logic [10:0] DAY_OF_MONTH_BCD_OFS     = 11'h7FD;
  localparam logic [10:0] MONTH_BCD_OFS            = 11'h7FE;
  localparam logic [10:0] YEAR_BCD_OFS             = 11'h7FF;
  localparam int unsigned STORE_DEPTH = 2040;          // Plain bytes below control

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int unsigned CTRL_TIME_LOAD_BIT  = 7;     // Freeze, load on clear
  localparam int unsigned CTRL_SNAPSHOT_BIT   = 6;     // Freeze for reading
  localparam int unsigned OSC_HALT_BIT        = 7;     // In seconds byte
  localparam int unsigned FREQ_TEST_BIT       = 6;     // In weekday byte

  // ----------------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------------
  localparam logic [7:0]  CTRL_RESET          = 8'h00;
  localparam logic        OSC_HALT_RESET      = 1'b1;  // Delivered stopped
  localparam logic [7:0]  SEC_RESET           = 8'h00;
  localparam logic [7:0]  MIN_RESET           = 8'h00;
  localparam logic [7:0]  HOUR_RESET          = 8'h00;
  localparam logic [7:0]  WDAY_RESET          = 8'h01;
  localparam logic [7:0]  MDAY_RESET          = 8'h01;
  localparam logic [7:0]  MONTH_RESET         = 8'h01;
  localparam logic [7:0]  YEAR_RESET          = 8'h00;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 200_000_000; // Reference clock
  localparam int unsigned SECOND_S        = 1;           // Clock step in s
  localparam int unsigned SEC_CYCLES      = SECOND_S * CLK_HZ;
  localparam int unsigned DIV_W           = 28;          // Divider width

endpackage

// ---- core/rtcs_store.sv ----
// Plain battery-backed byte storage below the clock registers
`timescale 1ns/10ps
`default_nettype none
module rtcs_store (
  input  wire logic        i_ref_clk,   // Reference clock
  input  wire logic        i_wr_en,     // Commit one byte
  input  wire logic [10:0] i_wr_addr,   // Byte to write
  input  wire logic [7:0]  i_wr_data,   // Value to write
  input  wire logic [10:0] i_rd_addr,   // Byte to read
  output logic      [7:0]  o_rd_data    // Combinational read value
);

  // ----------------------------------------------------------------------
  // Storage array
  // ----------------------------------------------------------------------
  // No reset: contents survive like a battery-backed array
  logic [7:0] mem_r [0:rtcs_pkg::STORE_DEPTH-1];

  // Single write port, one byte per completed cycle
  always_ff @(posedge i_ref_clk) begin
    if (i_wr_en && (i_wr_addr < rtcs_pkg::CLOCK_CONTROL_OFS)) begin
      mem_r[i_wr_addr] <= i_wr_data;
    end
  end

  // Read returns zero outside the array; the top substitutes clock bytes
  always_comb begin
    if (i_rd_addr < rtcs_pkg::CLOCK_CONTROL_OFS) begin
      o_rd_data = mem_r[i_rd_addr];
    end else begin
      o_rd_data = 8'h00;
    end
  end

endmodule
`default_nettype wire

// ---- core/rtcs_timekeep.sv ----
// Running BCD time counters with tick advance and parallel load
`timescale 1ns/10ps
`default_nettype none
module rtcs_timekeep (
  input  wire logic        i_ref_clk,  // Reference clock
  input  wire logic        i_reset,    // Async reset, active high
  input  wire logic        i_tick,     // One-second advance pulse
  input  wire logic        i_load,     // Load all counters at once
  input  wire logic [55:0] i_load_val, // Bytes sec..year, sec lowest
  output logic      [55:0] o_count     // Running counters, same layout
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // BCD step: returns {carry, next}; out-of-range values also wrap
  function automatic logic [8:0] bcd_step(input logic [7:0] v, input logic [7:0] top,
                                          input logic [7:0] first);
    if (v >= top) begin
      bcd_step = {1'b1, first};
    end else if (v[3:0] >= 4'h9) begin
      bcd_step = {1'b0, v[7:4] + 4'h1, 4'h0};
    end else begin
      bcd_step = {1'b0, v[7:4], v[3:0] + 4'h1};
    end
  endfunction

  // Last date of a month, leap years every fourth two-digit year
  function automatic logic [7:0] month_end(input logic [7:0] mon, input logic [7:0] yr);
    logic leap;
    leap = (!yr[4] && (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8)) ||
           (yr[4] && (yr[3:0] == 4'h2 || yr[3:0] == 4'h6));
    if (mon == 8'h02) begin
      month_end = leap ? 8'h29 : 8'h28;
    end else if (mon == 8'h04 || mon == 8'h06 || mon == 8'h09 || mon == 8'h11) begin
      month_end = 8'h30;
    end else begin
      month_end = 8'h31;
    end
  endfunction

  // ----------------------------------------------------------------------
  // Counter chain
  // ----------------------------------------------------------------------
  logic [7:0] sec_r, min_r, hour_r, wday_r, mday_r, mon_r, yr_r; // Counters
  logic [8:0] s_nxt, m_nxt, h_nxt, w_nxt, d_nxt, mo_nxt, y_nxt;  // Steps

  // Ripple of carries from seconds up to years
  always_comb begin
    s_nxt  = bcd_step(sec_r, 8'h59, 8'h00);
    m_nxt  = bcd_step(min_r, 8'h59, 8'h00);
    h_nxt  = bcd_step(hour_r, 8'h23, 8'h00);
    w_nxt  = bcd_step(wday_r, 8'h07, 8'h01);
    d_nxt  = bcd_step(mday_r, month_end(mon_r, yr_r), 8'h01);
    mo_nxt = bcd_step(mon_r, 8'h12, 8'h01);
    y_nxt  = bcd_step(yr_r, 8'h99, 8'h00);
  end

  // Load has priority so a new time is never half-advanced
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      sec_r  <= rtcs_pkg::SEC_RESET;
      min_r  <= rtcs_pkg::MIN_RESET;
      hour_r <= rtcs_pkg::HOUR_RESET;
      wday_r <= rtcs_pkg::WDAY_RESET;
      mday_r <= rtcs_pkg::MDAY_RESET;
      mon_r  <= rtcs_pkg::MONTH_RESET;
      yr_r   <= rtcs_pkg::YEAR_RESET;
    end else if (i_load) begin
      sec_r  <= {1'b0, i_load_val[6:0]};
      min_r  <= {1'b0, i_load_val[14:8]};
      hour_r <= {2'b00, i_load_val[21:16]};
      wday_r <= {5'h00, i_load_val[26:24]};
      mday_r <= {2'b00, i_load_val[37:32]};
      mon_r  <= {3'h0, i_load_val[44:40]};
      yr_r   <= i_load_val[55:48];
    end else if (i_tick) begin
      sec_r <= s_nxt[7:0];
      if (s_nxt[8]) begin
        min_r <= m_nxt[7:0];
        if (m_nxt[8]) begin
          hour_r <= h_nxt[7:0];
          if (h_nxt[8]) begin
            wday_r <= w_nxt[7:0];
            mday_r <= d_nxt[7:0];
            if (d_nxt[8]) begin
              mon_r <= mo_nxt[7:0];
              if (mo_nxt[8]) begin
                yr_r <= y_nxt[7:0];
              end
            end
          end
        end
      end
    end
  end

  assign o_count = {yr_r, mon_r, mday_r, wday_r, hour_r, min_r, sec_r};

endmodule
`default_nettype wire

// ---- dv/rtcs_chk.sv ----
// Checker: port-level assertions of the clock-register front end
`timescale 1ns/10ps
`default_nettype none
module rtcs_chk (
  input wire logic i_ref_clk,         // Clock
  input wire logic i_reset,           // Async reset
  input wire logic i_ce_n,            // Chip enable
  input wire logic i_oe_n,            // Output enable
  input wire logic i_we_n,            // Write enable
  input wire logic i_power_fail,      // Supply failing
  input wire logic i_supply_above_so, // Supply good
  input wire logic i_battery_weak,    // Battery check
  input wire logic o_dq_oe_n,         // Drives when low
  input wire logic o_battery_backup,  // On battery
  input wire logic o_battery_low,     // Low flag
  input wire logic o_osc_running      // Oscillator on
);
  // --------------------------------------------
  // Relations, one clock domain
  // --------------------------------------------
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);
  // Read seen at an edge, power good
  wire rd_on = !(i_ce_n | i_oe_n | !i_we_n | i_power_fail);
  a_read_drives:
    assert property (rd_on |=> !o_dq_oe_n) else $error("read not driven");
  a_idle_floats:
    assert property (i_ce_n || i_oe_n || !i_we_n |=> o_dq_oe_n) else $error("idle bus driven");
  a_fail_floats:
    assert property (i_power_fail |=> o_dq_oe_n) else $error("driven in power fail");
  a_backup_on:
    assert property (!i_supply_above_so |=> o_battery_backup) else $error("no battery backup");
  a_flag_sets:
    assert property ($fell(i_power_fail) && i_battery_weak |-> ##[0:3] o_battery_low)
      else $error("battery flag not set");
  a_flag_clears:
    assert property ($fell(o_battery_low) |-> $past(i_we_n) && !$past(i_we_n, 2))
      else $error("flag cleared without write");
  a_osc_starts:
    assert property ($rose(o_osc_running) |-> !$past(i_we_n, 3)) else $error("start no write");
  a_osc_stops:
    assert property ($fell(o_osc_running) |-> !$past(i_we_n, 3)) else $error("stop no write");
endmodule
bind rtcs_top rtcs_chk rtcs_chk_inst (.i_ref_clk, .i_reset, .i_ce_n, .i_oe_n, .i_we_n,
  .i_power_fail, .i_supply_above_so, .i_battery_weak, .o_dq_oe_n, .o_battery_backup,
  .o_battery_low, .o_osc_running);
`default_nettype wire

// ---- dv/rtcs_host.sv ----
// Host model: asynchronous memory-bus master
`timescale 1ns/10ps
`default_nettype none
module rtcs_host (
  input  wire logic        i_ref_clk, // Clock
  input  wire logic [7:0]  i_dq,      // Data from device
  input  wire logic        i_dq_oe_n, // Device driving
  output logic             o_ce_n,    // Chip enable
  output logic             o_oe_n,    // Output enable
  output logic             o_we_n,    // Write enable
  output logic      [10:0] o_addr,    // Address
  output logic      [7:0]  o_dq       // Write data
);
  // --------------------------------------------
  // Bus cycles, launched on falling edges
  // --------------------------------------------
  initial begin
    {o_ce_n, o_oe_n, o_we_n} = 3'b111;
    o_addr = 11'h000;
    o_dq = 8'h00;
  end
  // Both enables low one cycle, then high together
  task automatic wr(input logic [10:0] a, input logic [7:0] d);
    @(negedge i_ref_clk);
    {o_ce_n, o_we_n, o_addr, o_dq} = {2'b00, a, d};
    @(negedge i_ref_clk);
    {o_ce_n, o_we_n} = 2'b11;
    @(negedge i_ref_clk);
    o_dq = ~d; // Released lines never keep the old value
    o_addr = ~a;
  endtask
  // Data taken one edge after select
  task automatic rd(input logic [10:0] a, output logic [7:0] d, output logic z);
    @(negedge i_ref_clk);
    {o_ce_n, o_oe_n, o_addr} = {2'b00, a};
    @(negedge i_ref_clk);
    d = i_dq;
    z = i_dq_oe_n;
    {o_ce_n, o_oe_n, o_addr} = {2'b11, ~a};
  endtask
endmodule
`default_nettype wire

// ---- dv/tb_rtcs_top.sv ----
// Testbench: bus, power-fail and timekeeping checks of the front end
`timescale 1ns/10ps
`default_nettype none
module tb_rtcs_top;
  // --------------------------------------------
  // Signals and instances
  // --------------------------------------------
  logic i_ref_clk, i_reset, i_ce_n, i_oe_n, i_we_n, o_dq_oe_n, rz; // Bus and clock
  logic i_power_fail, i_supply_above_so, i_battery_weak;           // Power inputs
  logic o_battery_backup, o_battery_low, o_osc_running;            // Status
  logic [10:0] i_addr;                                             // Address
  logic [7:0]  i_dq, o_dq, rv;                                     // Data
  int          n_mismatch, check_count;                            // Tallies
  logic [7:0]  rst_img [8] = '{8'h00, 8'h80, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00};
  logic [7:0]  set_img [7] = '{8'h59, 8'h59, 8'h23, 8'h07, 8'h31, 8'h12, 8'h99};
  logic [7:0]  new_img [7] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00};
  rtcs_top #(.SEC_CYCLES(20)) rtcs_top_inst (.i_ref_clk, .i_reset, .i_ce_n, .i_oe_n, .i_we_n,
    .i_addr, .i_dq, .o_dq, .o_dq_oe_n, .i_power_fail, .i_supply_above_so, .i_battery_weak,
    .o_battery_backup, .o_battery_low, .o_osc_running);
  rtcs_host rtcs_host_inst (.i_ref_clk, .i_dq(o_dq), .i_dq_oe_n(o_dq_oe_n), .o_ce_n(i_ce_n),
    .o_oe_n(i_oe_n), .o_we_n(i_we_n), .o_addr(i_addr), .o_dq(i_dq));
  // --------------------------------------------
  // Helpers
  // --------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] want);
    check_count++;
    if (seen !== want) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic rc(input logic [10:0] a, input logic [7:0] want);
    rtcs_host_inst.rd(a, rv, rz);
    chk(rv, want);
    chk({7'h0, rz}, 8'h00);
  endtask
  task automatic conclude;
    if (n_mismatch == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    i_ref_clk = 1'b0;
    forever #2.5 i_ref_clk = ~i_ref_clk;
  end
  // Whole run is far below this
  initial begin
    #20000;
    n_mismatch++;
    conclude();
  end
  // --------------------------------------------
  // Sequence
  // --------------------------------------------
  initial begin
    {i_reset, i_power_fail, i_supply_above_so, i_battery_weak} = 4'b1010;
    n_mismatch = 0;
    check_count = 0;
    repeat (10) @(negedge i_ref_clk);
    i_reset = 1'b0;
    foreach (rst_img[k]) rc(11'h7F8 + 11'(k), rst_img[k]);
    chk({7'h0, o_osc_running}, 8'h00);
    rtcs_host_inst.wr(11'h000, 8'hA5);
    rtcs_host_inst.wr(11'h7F7, 8'h5A);
    rc(11'h000, 8'hA5);
    fork
      rtcs_host_inst.wr(11'h000, 8'h3C);
      begin
        repeat (2) @(negedge i_ref_clk);
        {i_power_fail, i_supply_above_so} = 2'b10;
      end
    join
    rtcs_host_inst.rd(11'h000, rv, rz);
    chk({7'h0, rz}, 8'h01);
    chk({7'h0, o_battery_backup}, 8'h01);
    {i_power_fail, i_supply_above_so, i_battery_weak} = 3'b011;
    rc(11'h000, 8'hA5);
    rc(11'h7F7, 8'h5A);
    chk({7'h0, o_battery_backup}, 8'h00);
    @(negedge i_ref_clk);
    i_power_fail = 1'b1;
    @(negedge i_ref_clk);
    i_power_fail = 1'b0;
    repeat (4) @(negedge i_ref_clk);
    chk({7'h0, o_battery_low}, 8'h01);
    i_battery_weak = 1'b0;
    rtcs_host_inst.wr(11'h7F7, 8'h11);
    rc(11'h7F7, 8'h5A);
    chk({7'h0, o_battery_low}, 8'h00);
    rtcs_host_inst.wr(11'h7F7, 8'h22);
    rc(11'h7F7, 8'h22);
    rtcs_host_inst.wr(11'h7F8, 8'h80);
    foreach (set_img[k]) rtcs_host_inst.wr(11'h7F9 + 11'(k), set_img[k]);
    rc(11'h7FB, 8'h23);
    rtcs_host_inst.wr(11'h7F8, 8'h00);
    // Wait for the first tick after the load
    for (int n = 0; n < 60 && rv !== 8'h00; n++) rtcs_host_inst.rd(11'h7F9, rv, rz);
    chk(rv, 8'h00);
    rtcs_host_inst.wr(11'h7F8, 8'h40);
    foreach (new_img[k]) rc(11'h7F9 + 11'(k), new_img[k]);
    repeat (50) @(negedge i_ref_clk);
    rc(11'h7F9, 8'h00);
    rc(11'h7F8, 8'h40);
    rtcs_host_inst.wr(11'h7F8, 8'h00);
    rtcs_host_inst.rd(11'h7F9, rv, rz);
    chk({7'h0, rv > 8'h01}, 8'h01);
    rtcs_host_inst.wr(11'h7F9, 8'h80);
    repeat (3) @(negedge i_ref_clk);
    chk({7'h0, o_osc_running}, 8'h00);
    conclude();
  end
endmodule
`default_nettype wire
